// ### core/ds_decode_pkg.sv
/*
  Constants for the data-space decoder and EEPROM access port.
  Assumes a single 50 MHz CPU clock and a synchronous active-high reset.

// Summary of operation
// - Registers, standard I/O, extended I/O, then SRAM
// - 2816 locations contiguous; SRAM 0x100 to end
// - Extended I/O only via load/store
// - Short I/O instruction field spans 64
// - Displacement up to 63 on upper pairs
// - Pointer pairs in 26..31; pre-decrement, post-increment
// - Direct addressing reaches whole data space
// - SRAM access takes two CPU clocks
// - EEPROM read stalls CPU four cycles
// - EEPROM write stalls CPU two cycles
// - EEPROM separate byte-addressed space
// - Address bits 15..12 read zero
// - EEPROM addressed linearly to last address
// - Self-timed write with pollable busy flag
// - Writes need arm-then-strobe sequence
// - EEPROM registers live in I/O space
// - Program memory is 16-bit words, 16K deep
// - Program counter is 16 bits, word addressed
// - Arm bit clears four cycles after set
// - Program strobe clears when write done
// - Read data returned within same instruction
// - Reads and address changes blocked while busy
*/
package ds_decode_pkg;
  localparam int unsigned DATA_AW       = 16;
  localparam int unsigned PC_W          = 16;
  localparam int unsigned PROG_WORDS    = 16384;
  localparam logic [15:0] REGS_FIRST    = 16'h0000;
  localparam logic [15:0] IO_FIRST      = 16'h0020;
  localparam logic [15:0] EXT_FIRST     = 16'h0060;
  localparam logic [15:0] SRAM_FIRST    = 16'h0100;
  localparam logic [15:0] SRAM_LAST_BIG = 16'h0AFF;
  localparam logic [15:0] SRAM_LAST_SML = 16'h05FF;
  localparam logic [15:0] EE_LAST_BIG   = 16'h03FF;
  localparam logic [15:0] EE_LAST_SML   = 16'h01FF;
  localparam logic [5:0]  DISP_MAX      = 6'h3F;
  localparam logic [4:0]  PTR_X_LO      = 5'h1A;
  localparam logic [4:0]  PTR_Y_LO      = 5'h1C;
  localparam logic [4:0]  PTR_Z_LO      = 5'h1E;
  // I/O-space offsets (short I/O encoding) for the EEPROM port
  localparam logic [5:0]  IO_EE_CTRL    = 6'h1F;
  localparam logic [5:0]  IO_EE_DATA    = 6'h20;
  localparam logic [5:0]  IO_EE_ADDR_LO = 6'h21;
  localparam logic [5:0]  IO_EE_ADDR_HI = 6'h22;
  // Control register bit positions
  localparam int unsigned CTL_READ      = 0;
  localparam int unsigned CTL_PROG      = 1;
  localparam int unsigned CTL_ARM       = 2;
  localparam logic [3:0]  ADDR_HI_MASK  = 4'h0;
  // Timing
  localparam int unsigned CLK_HZ        = 50000000;
  localparam int unsigned ARM_CYCLES    = 4;
  localparam int unsigned READ_STALL    = 4;
  localparam int unsigned WRITE_STALL   = 2;
  localparam int unsigned SRAM_CYCLES   = 2;
  localparam int unsigned PROG_TIME_US  = 3300;
  localparam int unsigned PROG_CYCLES   = (PROG_TIME_US * (CLK_HZ / 1000000));
  localparam logic [7:0]  UNMAPPED_READ = 8'hFF;

  typedef enum logic [1:0] {
    REGION_REGS = 2'b00,
    REGION_IO   = 2'b01,
    REGION_SRAM = 2'b10,
    REGION_NONE = 2'b11
  } region_t;
endpackage

// ### core/stall_counter.sv
/*
  Small down-counter used for the arm window and CPU stall counts.
  Assumes synchronous active-high reset on i_clock.
*/
`timescale 1ns/1ps
`default_nettype none
module stall_counter #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_sys_rst,
  // Control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  // State
  output logic              o_busy
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } cnt_state_t;

  cnt_state_t st;
  cnt_state_t next_st;

  always_comb begin
    next_st = st;
    if (i_load) begin
      next_st.cnt = i_count;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_busy = (st.cnt != '0);
endmodule
`default_nettype wire

// ### core/addr_decode.sv
/*
  Combinational data-space decoder and pointer arithmetic.
  Assumes addresses come from the CPU on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module addr_decode
  import ds_decode_pkg::*;
#(
  parameter logic [15:0] SRAM_LAST = 16'h0AFF
) (
  // Direct and short I/O address
  input  wire logic [15:0]   i_addr,
  input  wire logic          i_short_io,
  input  wire logic [5:0]    i_io_addr,
  // Indirect addressing
  input  wire logic [15:0]   i_ptr,
  input  wire logic [5:0]    i_disp,
  input  wire logic [1:0]    i_ptr_mode,
  // Results
  output ds_decode_pkg::region_t o_region,
  output logic [15:0]        o_eff_addr,
  output logic [15:0]        o_ptr_next
);
  import ds_decode_pkg::*;
  logic [15:0] addr;

  always_comb begin
    o_ptr_next = i_ptr;
    addr       = i_addr;
    if (i_short_io) begin
      addr = IO_FIRST + {10'h000, i_io_addr};
    end else begin
      unique case (i_ptr_mode)
        2'b00: addr = i_addr;
        2'b01: addr = i_ptr + {10'h000, (i_disp & DISP_MAX)};
        2'b10: begin
          addr       = i_ptr - 16'h0001;
          o_ptr_next = addr;
        end
        2'b11: begin
          addr       = i_ptr;
          o_ptr_next = i_ptr + 16'h0001;
        end
      endcase
    end
    o_eff_addr = addr;
    if (addr < IO_FIRST) begin
      o_region = REGION_REGS;
    end else if (addr < SRAM_FIRST) begin
      o_region = REGION_IO;
    end else if (addr <= SRAM_LAST) begin
      o_region = REGION_SRAM;
    end else begin
      o_region = REGION_NONE;
    end
  end
endmodule
`default_nettype wire

// ### core/data_space_decode_eeprom_port.sv
/*
  Data-space decoder, SRAM timing and EEPROM access port.
  Assumes a CPU core on i_clock that holds requests while o_stall is high,
  and an EEPROM array modelled here as an internal byte array.
*/
`timescale 1ns/1ps
`default_nettype none
module data_space_decode_eeprom_port
  import ds_decode_pkg::*;
#(
  parameter bit          BIG_VARIANT = 1'b1,
  parameter int unsigned PROG_CNT    = PROG_CYCLES
) (
  // Clock and reset
  input  wire logic          i_clock,
  input  wire logic          i_sys_rst,
  // CPU data access
  input  wire logic          i_req,
  input  wire logic          i_we,
  input  wire logic [15:0]   i_addr,
  input  wire logic          i_short_io,
  input  wire logic [5:0]    i_io_addr,
  input  wire logic [15:0]   i_ptr,
  input  wire logic [5:0]    i_disp,
  input  wire logic [1:0]    i_ptr_mode,
  input  wire logic [7:0]    i_wdata,
  // Decoder results
  output ds_decode_pkg::region_t o_region,
  output logic [15:0]        o_eff_addr,
  output logic [15:0]        o_ptr_next,
  output logic               o_sram_sel,
  output logic               o_io_sel,
  // Answer
  output logic [7:0]         o_rdata,
  output logic               o_ack,
  output logic               o_stall,
  // Program counter
  input  wire logic          i_pc_load,
  input  wire logic [15:0]   i_pc_value,
  input  wire logic          i_pc_step,
  output logic [15:0]        o_program_counter,
  // EEPROM status
  output logic               o_eeprom_busy
);
  import ds_decode_pkg::*;

  localparam logic [15:0] SRAM_LAST = BIG_VARIANT ? SRAM_LAST_BIG : SRAM_LAST_SML;
  localparam logic [15:0] EE_LAST   = BIG_VARIANT ? EE_LAST_BIG : EE_LAST_SML;
  localparam int unsigned EE_DEPTH  = 32'(EE_LAST_BIG) + 32'd1;
  localparam int unsigned SRAM_DEPTH = 32'(SRAM_LAST_BIG - SRAM_FIRST) + 32'd1;
  localparam int unsigned PW        = $clog2(PROG_CNT + 1);

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_SRAM = 2'b01,
    ACC_DONE = 2'b10
  } acc_t;

  typedef struct packed {
    acc_t        acc;
    logic [7:0]  rdata;
    logic        ack;
    logic [11:0] ee_addr;
    logic [7:0]  ee_data;
    logic        arm;
    logic        prog;
    logic [PW-1:0] prog_cnt;
    logic [15:0] pc;
  } state_t;

  state_t st;
  state_t next_st;

  logic [7:0] ee_mem [EE_DEPTH];
  logic [7:0] sram_mem [SRAM_DEPTH];
  logic [7:0] ee_rd_byte;
  logic [7:0] sram_rd_byte;

  region_t     region;
  logic [15:0] eff_addr;
  logic [15:0] sram_idx;

  addr_decode #(
    .SRAM_LAST (SRAM_LAST)
  ) u_decode (
    .i_addr     (i_addr),
    .i_short_io (i_short_io),
    .i_io_addr  (i_io_addr),
    .i_ptr      (i_ptr),
    .i_disp     (i_disp),
    .i_ptr_mode (i_ptr_mode),
    .o_region   (region),
    .o_eff_addr (eff_addr),
    .o_ptr_next (o_ptr_next)
  );

  // EEPROM register hits, in the I/O area
  logic io_hit;
  logic [5:0] io_off;
  logic hit_ctl, hit_data, hit_alo, hit_ahi;
  logic set_arm, set_prog, set_read, start_prog;
  logic arm_busy, rd_stall, wr_stall;
  logic take;

  assign sram_idx = eff_addr - SRAM_FIRST;
  // One take per access: a request still up in its ack cycle is the same
  // access, and one held off by a stall waits until the stall has run out
  assign take     = i_req && !o_stall && !st.ack && (st.acc == ACC_IDLE);
  assign io_hit   = take && (region == REGION_IO) && (eff_addr < EXT_FIRST);
  assign io_off   = eff_addr[5:0] - IO_FIRST[5:0];
  assign hit_ctl  = io_hit && (io_off == IO_EE_CTRL);
  assign hit_data = io_hit && (io_off == IO_EE_DATA);
  assign hit_alo  = io_hit && (io_off == IO_EE_ADDR_LO);
  assign hit_ahi  = io_hit && (io_off == IO_EE_ADDR_HI);
  assign set_arm  = hit_ctl && i_we && i_wdata[CTL_ARM] && !i_wdata[CTL_PROG];
  assign set_prog = hit_ctl && i_we && i_wdata[CTL_PROG];
  assign set_read = hit_ctl && i_we && i_wdata[CTL_READ] && !st.prog;
  assign start_prog = set_prog && st.arm && !st.prog;
  assign ee_rd_byte   = ee_mem[st.ee_addr[9:0] & EE_LAST[9:0]];
  assign sram_rd_byte = sram_mem[sram_idx[11:0]];

  // Arm window: bit reads set on the four edges after the arming store;
  // the load is one short because the arm bit itself covers the first one
  stall_counter #(.W(3)) u_arm (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_load    (set_arm),
    .i_count   (3'(ARM_CYCLES - 1)),
    .o_busy    (arm_busy)
  );
  stall_counter #(.W(3)) u_rd_stall (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_load    (set_read),
    .i_count   (3'(READ_STALL)),
    .o_busy    (rd_stall)
  );
  stall_counter #(.W(3)) u_wr_stall (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_load    (start_prog),
    .i_count   (3'(WRITE_STALL)),
    .o_busy    (wr_stall)
  );

  always_comb begin
    next_st     = st;
    next_st.ack = 1'b0;
    next_st.arm = arm_busy && st.arm;
    if (set_arm) begin
      next_st.arm = 1'b1;
    end
    // Program counter, word addressed over the program store
    if (i_pc_load) begin
      next_st.pc = i_pc_value;
    end else if (i_pc_step) begin
      next_st.pc = st.pc + 16'h0001;
    end
    // Self-timed write
    if (st.prog) begin
      if (st.prog_cnt == '0) begin
        next_st.prog = 1'b0;
      end else begin
        next_st.prog_cnt = st.prog_cnt - 1'b1;
      end
    end
    if (start_prog) begin
      next_st.prog     = 1'b1;
      next_st.prog_cnt = PW'(PROG_CNT - 1);
      next_st.arm      = 1'b0;
    end
    unique case (st.acc)
      ACC_IDLE: begin
        if (take) begin
          if (region == REGION_SRAM) begin
            next_st.acc   = ACC_SRAM;
            next_st.rdata = sram_rd_byte;
          end else begin
            next_st.ack   = 1'b1;
            next_st.rdata = (region == REGION_NONE) ? UNMAPPED_READ : 8'h00;
            if (hit_data) begin
              next_st.rdata = st.ee_data;
            end
            if (hit_alo) begin
              next_st.rdata = st.ee_addr[7:0];
            end
            if (hit_ahi) begin
              next_st.rdata = {ADDR_HI_MASK, st.ee_addr[11:8]};
            end
            if (hit_ctl) begin
              next_st.rdata = {5'h00, st.arm, st.prog, 1'b0};
            end
            if (i_we && hit_data) begin
              next_st.ee_data = i_wdata;
            end
            if (i_we && hit_alo && !st.prog) begin
              next_st.ee_addr[7:0] = i_wdata;
            end
            if (i_we && hit_ahi && !st.prog) begin
              next_st.ee_addr[11:8] = i_wdata[3:0];
            end
            if (set_read) begin
              next_st.ee_data = ee_rd_byte;
            end
          end
        end
      end
      ACC_SRAM: begin
        next_st.acc = ACC_IDLE;
        next_st.ack = 1'b1;
      end
      default: begin
        next_st.acc = ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Arrays carry no reset; the EEPROM keeps contents across reset
  always_ff @(posedge i_clock) begin
    if (st.prog && st.prog_cnt == '0) begin
      ee_mem[st.ee_addr[9:0] & EE_LAST[9:0]] <= st.ee_data;
    end
    if (take && i_we && region == REGION_SRAM) begin
      sram_mem[sram_idx[11:0]] <= i_wdata;
    end
  end

  assign o_region          = region;
  assign o_eff_addr        = eff_addr;
  assign o_sram_sel        = i_req && (region == REGION_SRAM);
  assign o_io_sel          = i_req && (region == REGION_IO);
  assign o_rdata           = st.rdata;
  assign o_ack             = st.ack;
  assign o_stall           = rd_stall || wr_stall;
  assign o_program_counter = st.pc;
  assign o_eeprom_busy     = st.prog;

  // Checks on decode, access timing and the EEPROM port
  AST_SRAM_TWO: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (take && region == REGION_SRAM) |=> !o_ack ##1 o_ack)
    else $error("SRAM access not two cycles");
  AST_READ_STALL: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    set_read |=> o_stall [*4] ##1 !rd_stall)
    else $error("read stall not four cycles");
  AST_WRITE_STALL: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    start_prog |=> wr_stall [*2] ##1 !wr_stall)
    else $error("write stall not two cycles");
  AST_ARM_TIMEOUT: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (set_arm && !set_prog) ##1 (!set_prog && !set_arm) [*4] |=> !st.arm)
    else $error("arm bit outlived its window");
  AST_NO_UNARMED: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (!st.prog && !st.arm) |=> !st.prog)
    else $error("write started without arm");
  AST_ADDR_HOLD: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st.prog |=> st.ee_addr == $past(st.ee_addr))
    else $error("address changed during write");
  AST_HI_ZERO: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (st.acc == ACC_IDLE && hit_ahi && !o_stall) |=> o_rdata[7:4] == 4'h0)
    else $error("address high bits not zero");
  AST_PROG_CLEARS: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (st.prog && st.prog_cnt == '0) |=> !st.prog)
    else $error("program strobe not cleared");
  AST_UNMAPPED: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (take && region == REGION_NONE)
      |=> o_ack && o_rdata == UNMAPPED_READ)
    else $error("unmapped read value wrong");
  AST_ACK_PULSE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_ack |=> !o_ack)
    else $error("ack longer than one cycle");
  AST_READ_DATA: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    set_read |=> o_stall && st.ee_data == $past(ee_rd_byte))
    else $error("read strobe did not load data register");
  AST_READ_BLOCKED: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    st.prog |-> !set_read && !start_prog)
    else $error("read or write accepted while busy");
  AST_SHORT_IO: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_short_io |-> (eff_addr >= IO_FIRST && eff_addr < EXT_FIRST))
    else $error("short I/O address outside standard window");
  AST_PC_STEP: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (i_pc_step && !i_pc_load) |=> o_program_counter == $past(o_program_counter) + 16'h0001)
    else $error("program counter step wrong");
  AST_ARM_HELD: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    set_arm ##1 !set_prog [*3] |=> st.arm)
    else $error("arm bit dropped inside its window");
  AST_WRITE_LANDS: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    (st.prog && st.prog_cnt == '0)
      |=> ee_mem[st.ee_addr[9:0] & EE_LAST[9:0]] == $past(st.ee_data))
    else $error("EEPROM byte not written at end of write");
  AST_IO_SEL_RANGE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_io_sel |-> (eff_addr >= IO_FIRST && eff_addr < SRAM_FIRST))
    else $error("I/O select outside I/O area");
  AST_SRAM_SEL_RANGE: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_sram_sel |-> (eff_addr >= SRAM_FIRST && eff_addr <= SRAM_LAST))
    else $error("SRAM select outside SRAM area");
endmodule
`default_nettype wire

// ### verif/cpu_access_model.sv
/*
  Behavioural CPU core that runs a short script of load and store accesses.
  Assumes the block answers with o_ack and holds off requests with o_stall.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_access_model (
  // Clock
  input  wire logic        i_clock,
  // Script from the bench
  input  wire logic        i_start,
  input  wire logic [1:0]  i_count,
  input  wire logic        i_cmd_we   [3],
  input  wire logic [15:0] i_cmd_addr [3],
  input  wire logic [7:0]  i_cmd_data [3],
  input  wire logic [15:0] i_probe_addr,
  // Block answer
  input  wire logic        i_ack,
  input  wire logic        i_stall,
  input  wire logic [7:0]  i_rdata,
  // Block request
  output logic             o_req,
  output logic             o_we,
  output logic [15:0]      o_addr,
  output logic [7:0]       o_wdata,
  // Results
  output logic             o_done,
  output logic [7:0]       o_data,
  output logic [3:0]       o_lat,
  output logic [3:0]       o_stalls
);
  logic       active;
  logic [1:0] idx;
  logic [3:0] cnt;
  initial begin
    {active, idx, cnt, o_req, o_we, o_done, o_lat, o_stalls} = '0;
    o_wdata = 8'h00;
    o_data = 8'h00;
  end
  always @(posedge i_clock) begin
    if (!active) begin
      o_addr <= i_probe_addr;
    end
    if (i_stall && o_stalls != 4'hF) begin
      o_stalls <= o_stalls + 4'h1;
    end
    if (i_start && !active && !i_stall) begin
      // New scripts start only while the block is not stalling the core
      {active, o_req, o_done} <= 3'b110;
      {idx, cnt, o_stalls} <= '0;
      o_we <= i_cmd_we[0];
      o_addr <= i_cmd_addr[0];
      o_wdata <= i_cmd_data[0];
    end else if (active) begin
      cnt <= cnt + 4'h1;
      if (o_req && i_ack) begin
        o_data <= i_rdata;
        if (idx == 2'd0) begin
          o_lat <= cnt;
        end
        if (idx + 2'd1 < i_count) begin
          idx <= idx + 2'd1;
          o_we <= i_cmd_we[idx+1];
          o_addr <= i_cmd_addr[idx+1];
          o_wdata <= i_cmd_data[idx+1];
        end else begin
          // Released data lines do not keep the last value
          {active, o_req, o_done} <= 3'b001;
          o_wdata <= ~o_wdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/data_space_decode_eeprom_port_tb_top.sv
/*
  Self-checking bench for the data-space decoder and EEPROM port.
  Assumes the CPU model in cpu_access_model and a shortened write time.
*/
`timescale 1ns/1ps
`default_nettype none
module data_space_decode_eeprom_port_tb_top;
  import ds_decode_pkg::*;
  logic clk, rst, pc_load, pc_step, short_io, start, req, we, ack, stall, busy, done;
  logic [15:0] pc_val, ptr, probe, addr, eff, pnext, pc;
  logic [5:0] io_addr, disp;
  logic [1:0] mode, n;
  logic [7:0] wdata, rdata, data;
  logic [3:0] lat, stalls;
  logic cwe [3];
  logic [15:0] ca [3];
  logic [7:0] cd [3];
  region_t region;
  int fails, checks;

  data_space_decode_eeprom_port #(.BIG_VARIANT(1'b1), .PROG_CNT(20)) i_data_space_decode_eeprom_port (
    .i_clock(clk), .i_sys_rst(rst), .i_req(req), .i_we(we), .i_addr(addr),
    .i_short_io(short_io), .i_io_addr(io_addr), .i_ptr(ptr), .i_disp(disp),
    .i_ptr_mode(mode), .i_wdata(wdata), .o_region(region), .o_eff_addr(eff),
    .o_ptr_next(pnext), .o_sram_sel(), .o_io_sel(), .o_rdata(rdata), .o_ack(ack),
    .o_stall(stall), .i_pc_load(pc_load), .i_pc_value(pc_val), .i_pc_step(pc_step),
    .o_program_counter(pc), .o_eeprom_busy(busy));
  cpu_access_model i_cpu_access_model (
    .i_clock(clk), .i_start(start), .i_count(n), .i_cmd_we(cwe), .i_cmd_addr(ca),
    .i_cmd_data(cd), .i_probe_addr(probe), .i_ack(ack), .i_stall(stall),
    .i_rdata(rdata), .o_req(req), .o_we(we), .o_addr(addr), .o_wdata(wdata),
    .o_done(done), .o_data(data), .o_lat(lat), .o_stalls(stalls));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic cmd(input int i, input logic w, input logic [15:0] a, input logic [7:0] d);
    cwe[i] <= w;
    ca[i] <= a;
    cd[i] <= d;
  endtask
  // Runs the loaded script; the bound covers the longest stall plus SRAM waits
  task automatic run(input logic [1:0] k);
    int i;
    // The core ignores start while stalled, which would leave done stale
    for (i = 0; i < 20 && stall !== 1'b0; i++) @(posedge clk);
    if (stall !== 1'b0) begin
      fails++;
      $display("[ERR] stall before script expected 0 seen 1");
      wrap_up();
    end
    @(posedge clk);
    n <= k;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    // The core clears done on this edge; let it settle before polling
    @(posedge clk);
    for (i = 0; i < 40 && !done; i++) @(posedge clk);
    if (!done) begin
      fails++;
      $display("[ERR] script expected done seen timeout");
      wrap_up();
    end
  endtask

  task automatic t_decode;
    logic [15:0] a [8] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060,
                           16'h00FF, 16'h0100, 16'h0AFF, 16'h0B00};
    logic [1:0] r [8] = '{2'b00, 2'b01, 2'b01, 2'b01, 2'b01, 2'b10, 2'b10, 2'b11};
    for (int i = 0; i < 8; i++) begin
      probe <= a[i];
      cyc(2);
      chk("region", 16'(region), 16'(r[i]));
      chk("eff direct", eff, a[i]);
    end
    short_io <= 1'b1;
    io_addr <= 6'h3F;
    cyc(1);
    chk("eff short", eff, 16'h005F);
    short_io <= 1'b0;
    ptr <= 16'h0200;
    disp <= DISP_MAX;
    mode <= 2'b01;
    cyc(1);
    chk("eff disp", eff, 16'h023F);
    mode <= 2'b10;
    cyc(1);
    chk("eff predec", eff, 16'h01FF);
    chk("ptr predec", pnext, 16'h01FF);
    mode <= 2'b11;
    cyc(1);
    chk("eff postinc", eff, 16'h0200);
    chk("ptr postinc", pnext, 16'h0201);
    mode <= 2'b00;
    $display("test decode done");
  endtask

  task automatic t_pc;
    pc_val <= 16'hFFFF;
    pc_load <= 1'b1;
    cyc(1);
    pc_load <= 1'b0;
    pc_step <= 1'b1;
    cyc(1);
    pc_step <= 1'b0;
    cyc(1);
    chk("pc wrap", pc, 16'h0000);
    $display("test pc done");
  endtask

  task automatic t_sram;
    cmd(0, 1'b1, 16'h0100, 8'h3C);
    cmd(1, 1'b1, 16'h0AFF, 8'h5A);
    cmd(2, 1'b0, 16'h0100, 8'h00);
    run(3);
    chk("sram first", 16'(data), 16'h003C);
    chk("sram latency", 16'(lat), 16'(SRAM_CYCLES));
    cmd(0, 1'b0, 16'h0AFF, 8'h00);
    run(1);
    chk("sram last", 16'(data), 16'h005A);
    cmd(0, 1'b1, 16'h0B00, 8'h11);
    cmd(1, 1'b0, 16'h0B00, 8'h00);
    run(2);
    chk("unmapped", 16'(data), 16'(UNMAPPED_READ));
    $display("test sram done");
  endtask

  task automatic t_eeprom;
    int i;
    cmd(0, 1'b1, 16'h0041, 8'hFF);
    cmd(1, 1'b1, 16'h0042, 8'hFF);
    cmd(2, 1'b0, 16'h0042, 8'h00);
    run(3);
    chk("addr high top", 16'(data & 8'hF0), 16'h0000);
    chk("io latency", 16'(lat), 16'h0001);
    cmd(0, 1'b1, 16'h0042, 8'h03);
    cmd(1, 1'b1, 16'h0040, 8'hA5);
    run(2);
    cmd(0, 1'b1, 16'h003F, 8'h02);
    run(1);
    cyc(4);
    chk("strobe unarmed", 16'(busy), 16'h0000);
    cmd(0, 1'b1, 16'h003F, 8'h04);
    run(1);
    cyc(6);
    cmd(0, 1'b1, 16'h003F, 8'h02);
    run(1);
    cyc(3);
    chk("strobe late", 16'(busy), 16'h0000);
    cmd(0, 1'b1, 16'h003F, 8'h04);
    cmd(1, 1'b1, 16'h003F, 8'h02);
    run(2);
    cyc(6);
    chk("busy", 16'(busy), 16'h0001);
    chk("write stall", 16'(stalls), 16'(WRITE_STALL));
    cmd(0, 1'b1, 16'h0041, 8'h00);
    cmd(1, 1'b1, 16'h003F, 8'h01);
    run(2);
    cyc(6);
    chk("read while busy", 16'(stalls), 16'h0000);
    for (i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clk);
    chk("busy end", 16'(busy), 16'h0000);
    if (busy !== 1'b0) wrap_up();
    cmd(0, 1'b1, 16'h0040, 8'h00);
    cmd(1, 1'b1, 16'h003F, 8'h01);
    cmd(2, 1'b0, 16'h0040, 8'h00);
    run(3);
    chk("eeprom byte", 16'(data), 16'h00A5);
    chk("read stall", 16'(stalls), 16'(READ_STALL));
    cmd(0, 1'b0, 16'h0041, 8'h00);
    run(1);
    chk("addr kept", 16'(data), 16'h00FF);
    $display("test eeprom done");
  endtask

  initial begin
    {rst, pc_load, pc_step, short_io, start} = 5'b10000;
    {pc_val, ptr, probe} = '0;
    {io_addr, disp, mode, n} = '0;
    for (int i = 0; i < 3; i++) begin
      cwe[i] = 1'b0;
      ca[i] = 16'h0000;
      cd[i] = 8'h00;
    end
    fails = 0;
    checks = 0;
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    t_decode();
    t_pc();
    t_sram();
    t_eeprom();
    wrap_up();
  end
endmodule
`default_nettype wire
